// ===== hw/fpsv_top.sv
`timescale 1ns/1ps
module fpsv_top (
  input  wire logic                     clk,       // Core clock
  input  wire logic                     rst,       // Sync reset
  input  wire logic                     psel,      // APB select
  input  wire logic                     penable,   // APB enable
  input  wire logic                     pwrite,    // APB direction
  input  wire logic [fpsv_pkg::ADDR_W-1:0] paddr,  // APB address
  input  wire logic [31:0]              pwdata,    // APB write data
  output logic      [31:0]              prdata,    // APB read data
  output logic                          pready,    // APB ready
  output logic                          pslverr,   // APB error
  input  wire logic                     op_valid,  // Issue strobe
  input  wire fpsv_pkg::fpsv_op_t       op_code,   // Issued op
  input  wire logic [31:0]              op_a,      // Operand a
  input  wire logic [31:0]              op_b,      // Operand b
  input  wire logic [31:0]              op_c,      // Operand c
  output logic                          ar_valid,  // To arithmetic
  output fpsv_pkg::fpsv_op_t            ar_op,     // Forwarded op
  output logic      [31:0]              ar_a,      // Flushed a
  output logic      [31:0]              ar_b,      // Flushed b
  output logic      [31:0]              ar_c,      // Flushed c
  input  wire logic                     res_valid, // Unrounded ready
  input  wire logic                     res_sign,  // Unrounded sign
  input  wire logic signed [9:0]        res_exp,   // Unrounded exp
  input  wire logic [26:0]              res_mant,  // Unrounded mant
  input  wire logic                     res_inv,   // Invalid case
  input  wire logic [7:0]               res_org,   // Invalid origin
  output logic                          fin_valid, // Final result
  output logic      [31:0]              fin_word,  // Final word
  output logic                          imm_valid, // Direct result
  output logic      [31:0]              imm_word,  // Direct word
  output logic      [3:0]               cmp_flags, // Compare outcome
  output logic                          cmp_denorm,// Denormal seen
  output logic                          exc_pulse, // Exception event
  output logic      [1:0]               round_mode,// Rounding mode
  output logic                          flag_inv,  // Sticky invalid
  output logic                          flag_unf   // Sticky underflow
);
  import fpsv_pkg::*;

  // All registered state
  typedef struct packed {
    logic [1:0]  mode;
    logic        inv;
    logic        unf;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        ar_valid;
    fpsv_op_t    ar_op;
    logic [31:0] ar_a;
    logic [31:0] ar_b;
    logic [31:0] ar_c;
    logic        imm_valid;
    logic [31:0] imm_word;
    logic        fin_valid;
    logic [31:0] fin_word;
    logic [3:0]  cmp;
    logic        cmp_dn;
    logic        exc;
    logic [16:0] last;
  } fpsv_state_t;

  fpsv_state_t s_reg;       // Current state
  fpsv_state_t s_next;      // Next state
  fpsv_cls_if  ci [3] ();   // Operand class links
  logic [31:0] opw [3];     // Operand words
  logic [31:0] rnd_word;    // Rounder output
  logic        rnd_tiny;    // Rounder tininess
  logic        acc;         // APB access phase
  logic        wr_upd;      // APB status write commits
  logic        upd;         // Any flag update
  logic [31:0] upd_src;     // Flag update source
  logic [31:0] status;      // Status word image
  logic        is_ar;       // Arithmetic op issued
  logic [2:0]  use_m;       // Operands used by op
  logic        sn_any;      // Signalling NaN among used
  logic        qn_any;      // Quiet NaN among used
  logic        inv_set;     // Invalid raised
  logic        unf_set;     // Underflow raised
  logic [3:0]  cmp_v;       // Exact compare outcome

  assign opw[0] = op_a;
  assign opw[1] = op_b;
  assign opw[2] = op_c;

  // One classifier per operand
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cls
      assign ci[gi].word = opw[gi];
      fpsv_classify u_cls (
        .c (ci[gi])
      );
    end
  endgenerate

  // Rounding of unrounded results
  fpsv_round u_round (
    .sgn  (res_sign),
    .exp  (res_exp),
    .mant (res_mant),
    .mode (s_reg.mode),
    .word (rnd_word),
    .tiny (rnd_tiny)
  );

  // Operand use and NaN detection
  always_comb
  begin
    is_ar = (op_code == OP_ADD) || (op_code == OP_MUL) ||
            (op_code == OP_FMA) || (op_code == OP_FMS);
    case (op_code)
      OP_FMA, OP_FMS: use_m = 3'h7;
      OP_SEED:        use_m = 3'h1;
      OP_UPDF:        use_m = 3'h0;
      default:        use_m = 3'h3;
    endcase
    sn_any = (use_m[0] && ci[0].cls == CLS_SNAN) ||
             (use_m[1] && ci[1].cls == CLS_SNAN) ||
             (use_m[2] && ci[2].cls == CLS_SNAN);
    qn_any = (use_m[0] && ci[0].cls == CLS_QNAN) ||
             (use_m[1] && ci[1].cls == CLS_QNAN) ||
             (use_m[2] && ci[2].cls == CLS_QNAN);
  end

  // Exact compare on raw words, denormals kept
  always_comb
  begin
    if (ci[0].cls inside {CLS_SNAN, CLS_QNAN} ||
        ci[1].cls inside {CLS_SNAN, CLS_QNAN})
      cmp_v = CMP_UN;
    else if (op_a[30:0] == '0 && op_b[30:0] == '0)
      cmp_v = CMP_EQ;
    else if (op_a == op_b)
      cmp_v = CMP_EQ;
    else if (op_a[SIGN_BIT] != op_b[SIGN_BIT])
      cmp_v = op_a[SIGN_BIT] ? CMP_LT : CMP_GT;
    else if ((op_a[30:0] < op_b[30:0]) ^ op_a[SIGN_BIT])
      cmp_v = CMP_LT;
    else
      cmp_v = CMP_GT;
  end

  // Next-state logic
  always_comb
  begin
    s_next           = s_reg;
    s_next.pready    = 1'b0;
    s_next.pslverr   = 1'b0;
    s_next.ar_valid  = 1'b0;
    s_next.imm_valid = 1'b0;
    s_next.fin_valid = 1'b0;
    inv_set          = 1'b0;
    unf_set          = 1'b0;
    // Status word image
    status                = 32'h0000_0000;
    status[INV_BIT]       = s_reg.inv;
    status[UNF_BIT]       = s_reg.unf;
    status[RND_HI:RND_LO] = s_reg.mode;
    // APB slave, one wait state
    acc    = psel && penable;
    wr_upd = acc && s_reg.pready && pwrite && !s_reg.pslverr &&
             (paddr == REG_STATUS);
    if (acc && !s_reg.pready)
    begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      if (paddr == REG_STATUS)
        s_next.prdata = status;
      else if (paddr == REG_LAST)
        s_next.prdata = {15'h0000, s_reg.last};
      else
        s_next.pslverr = 1'b1;
    end
    // Issue side
    if (op_valid)
    begin
      s_next.last = {ci[0].cls, ci[1].cls, s_reg.cmp_dn, s_reg.cmp};
      if (is_ar)
      begin
        if (sn_any)
        begin
          // Signalling input is invalid
          s_next.imm_valid = 1'b1;
          s_next.imm_word  = QNAN_SNAN;
          inv_set          = 1'b1;
        end
        else if (qn_any)
        begin
          // Quiet input never propagates
          s_next.imm_valid = 1'b1;
          s_next.imm_word  = QNAN_FIXED;
        end
        else
        begin
          // Forward flushed operands
          s_next.ar_valid = 1'b1;
          s_next.ar_op    = op_code;
          s_next.ar_a     = ci[0].flushed;
          s_next.ar_b     = ci[1].flushed;
          s_next.ar_c     = ci[2].flushed;
        end
      end
      else if (op_code == OP_CMP)
      begin
        // Exact compare and denormal report
        s_next.imm_valid = 1'b1;
        s_next.imm_word  = {28'h000_0000, cmp_v};
        s_next.cmp       = cmp_v;
        s_next.cmp_dn    = (ci[0].cls == CLS_DEN) ||
                           (ci[1].cls == CLS_DEN);
        inv_set          = sn_any;
      end
      else if (op_code == OP_SEED)
      begin
        // Square-root seed only
        s_next.imm_valid = 1'b1;
        if (sn_any || ((ci[0].cls == CLS_NORM || ci[0].cls == CLS_INF)
            && op_a[SIGN_BIT]))
        begin
          s_next.imm_word = sn_any ? QNAN_SNAN : QNAN_SEED;
          inv_set         = 1'b1;
        end
        else if (qn_any)
          s_next.imm_word = QNAN_FIXED;
        else if (ci[0].cls inside {CLS_ZERO, CLS_DEN})
          s_next.imm_word = {op_a[SIGN_BIT], EXP_ONES, 23'h00_0000};
        else if (ci[0].cls == CLS_INF)
          s_next.imm_word = 32'h0000_0000;
        else
          s_next.imm_word = SEED_MAGIC - {1'b0, op_a[31:1]};
      end
    end
    // Result side, single rounding
    if (res_valid)
    begin
      s_next.fin_valid = 1'b1;
      if (res_inv)
      begin
        s_next.fin_word = QNAN_FIXED | {24'h00_0000, res_org};
        inv_set         = 1'b1;
      end
      else
      begin
        s_next.fin_word = rnd_word;
        unf_set         = rnd_tiny;
      end
    end
    // Flag update; a raised flag wins over clear
    upd     = wr_upd || (op_valid && op_code == OP_UPDF);
    upd_src = wr_upd ? pwdata : op_a;
    if (upd)
      s_next.mode = upd_src[RND_HI:RND_LO];
    s_next.inv = (upd ? upd_src[INV_BIT] : s_reg.inv) | inv_set;
    s_next.unf = (upd ? upd_src[UNF_BIT] : s_reg.unf) | unf_set;
    s_next.exc = inv_set | unf_set;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg      <= '0;
      s_reg.mode <= RND_NEAR;
    end
    else
      s_reg <= s_next;
  end

  // Outputs straight from the state register
  assign prdata     = s_reg.prdata;
  assign pready     = s_reg.pready;
  assign pslverr    = s_reg.pslverr;
  assign ar_valid   = s_reg.ar_valid;
  assign ar_op      = s_reg.ar_op;
  assign ar_a       = s_reg.ar_a;
  assign ar_b       = s_reg.ar_b;
  assign ar_c       = s_reg.ar_c;
  assign fin_valid  = s_reg.fin_valid;
  assign fin_word   = s_reg.fin_word;
  assign imm_valid  = s_reg.imm_valid;
  assign imm_word   = s_reg.imm_word;
  assign cmp_flags  = s_reg.cmp;
  assign cmp_denorm = s_reg.cmp_dn;
  assign exc_pulse  = s_reg.exc;
  assign round_mode = s_reg.mode;
  assign flag_inv   = s_reg.inv;
  assign flag_unf   = s_reg.unf;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  qnan_fixed_a: assert property (
    op_valid && is_ar && qn_any && !sn_any
    |=> imm_valid && imm_word == QNAN_FIXED && !ar_valid)
    else $error("quiet NaN input did not give fixed NaN");
  snan_invalid_a: assert property (
    op_valid && is_ar && sn_any
    |=> flag_inv && exc_pulse && imm_word[QUIET_BIT])
    else $error("signalling NaN not flagged invalid");
  flush_operand_a: assert property (
    op_valid && is_ar && !qn_any && !sn_any && ci[0].cls == CLS_DEN
    |=> ar_valid && ar_a[30:0] == '0 && ar_a[31] == $past(op_a[31]))
    else $error("denormal operand not flushed");
  cmp_denorm_a: assert property (
    op_valid && op_code == OP_CMP && ci[1].cls == CLS_DEN
    |=> cmp_denorm && imm_valid)
    else $error("compare missed denormal operand");
  zero_equal_a: assert property (
    op_valid && op_code == OP_CMP && op_a[30:0] == '0 &&
    op_b[30:0] == '0 |=> cmp_flags == CMP_EQ)
    else $error("signed zeros compared unequal");
  underflow_set_a: assert property (
    res_valid && !res_inv && res_mant != '0 && res_exp < 10'sh001
    |=> flag_unf ##1 flag_unf || $past(upd))
    else $error("tiny result did not flag underflow");
  no_denorm_res_a: assert property (
    fin_valid && fin_word[EXP_HI:EXP_LO] == EXP_NONE
    |-> fin_word[QUIET_BIT:0] == '0)
    else $error("denormal result left unflushed");
  flags_sticky_a: assert property (
    flag_inv && !upd |=> flag_inv)
    else $error("invalid flag cleared without update");
  mode_reset_a: assert property (
    $past(rst) |-> round_mode == RND_NEAR && !flag_inv && !flag_unf)
    else $error("rounding mode not nearest after reset");

  fma_fwd_c: cover property (
    op_valid && op_code == OP_FMA ##1 ar_valid);
  unf_evt_c: cover property (res_valid && rnd_tiny ##1 exc_pulse);
  apb_wr_c: cover property (wr_upd ##1 !pready);
endmodule : fpsv_top

// ===== hw/fpsv_pkg.sv
package fpsv_pkg;
  // Word layout
  localparam int          SIGN_BIT  = 31;
  localparam int          EXP_HI    = 30;
  localparam int          EXP_LO    = 23;
  localparam int          QUIET_BIT = 22;
  localparam logic [7:0]  EXP_ONES  = 8'hFF;
  localparam logic [7:0]  EXP_NONE  = 8'h00;
  // Fixed and origin-coded NaN results
  localparam logic [31:0] QNAN_FIXED = 32'h7FC0_0000;
  localparam logic [31:0] QNAN_SNAN  = 32'h7FC0_0001;
  localparam logic [31:0] QNAN_SEED  = 32'h7FC0_0002;
  // Square-root seed constant
  localparam logic [31:0] SEED_MAGIC = 32'h5F37_59DF;
  // Rounding mode encodings
  localparam logic [1:0]  RND_NEAR  = 2'h0;
  localparam logic [1:0]  RND_POS   = 2'h1;
  localparam logic [1:0]  RND_NEG   = 2'h2;
  localparam logic [1:0]  RND_ZERO  = 2'h3;
  // Status word fields
  localparam int          INV_BIT   = 30;
  localparam int          UNF_BIT   = 27;
  localparam int          RND_HI    = 25;
  localparam int          RND_LO    = 24;
  // Register map
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_LAST   = 12'h004;
  // Unrounded result format
  localparam int          REXP_W    = 10;
  localparam int          RMANT_W   = 27;
  // Compare result encodings
  localparam logic [3:0]  CMP_LT    = 4'h1;
  localparam logic [3:0]  CMP_EQ    = 4'h2;
  localparam logic [3:0]  CMP_GT    = 4'h4;
  localparam logic [3:0]  CMP_UN    = 4'h8;
  // Operation codes
  typedef enum logic [2:0] {
    OP_ADD  = 3'h0,
    OP_MUL  = 3'h1,
    OP_FMA  = 3'h2,
    OP_FMS  = 3'h3,
    OP_CMP  = 3'h4,
    OP_SEED = 3'h5,
    OP_UPDF = 3'h6
  } fpsv_op_t;
  // Operand classes, one-hot
  typedef enum logic [5:0] {
    CLS_NORM = 6'h01,
    CLS_DEN  = 6'h02,
    CLS_ZERO = 6'h04,
    CLS_INF  = 6'h08,
    CLS_SNAN = 6'h10,
    CLS_QNAN = 6'h20
  } fpsv_cls_t;
endpackage : fpsv_pkg

// ===== hw/fpsv_cls_if.sv
`timescale 1ns/1ps
interface fpsv_cls_if;
  logic [31:0]         word;    // Raw operand
  fpsv_pkg::fpsv_cls_t cls;     // Operand class
  logic [31:0]         flushed; // Operand with denormal flushed
  modport cls_side (input word, output cls, output flushed);
  modport use_side (output word, input cls, input flushed);
endinterface : fpsv_cls_if

// ===== hw/fpsv_classify.sv
`timescale 1ns/1ps
module fpsv_classify (
  fpsv_cls_if.cls_side c // Operand and its class
);
  import fpsv_pkg::*;
  logic        sgn; // Sign field
  logic [7:0]  ex;  // Biased exponent field
  logic [22:0] fr;  // Fraction field
  // Split word into fields
  assign sgn = c.word[SIGN_BIT];
  assign ex  = c.word[EXP_HI:EXP_LO];
  assign fr  = c.word[QUIET_BIT:0];
  // Classify and flush
  always_comb
  begin
    c.flushed = c.word;
    if (ex == EXP_NONE)
    begin
      // Zero or denormal
      c.cls = (fr == '0) ? CLS_ZERO : CLS_DEN;
      c.flushed = {sgn, 31'h0000_0000};
    end
    else if (ex == EXP_ONES)
    begin
      // Infinity or NaN, quiet bit decides
      if (fr == '0)
        c.cls = CLS_INF;
      else
        c.cls = fr[QUIET_BIT] ? CLS_QNAN : CLS_SNAN;
    end
    else
      c.cls = CLS_NORM;
  end
endmodule : fpsv_classify

// ===== hw/fpsv_round.sv
`timescale 1ns/1ps
module fpsv_round (
  input  wire logic                sgn,  // Result sign
  input  wire logic signed [9:0]   exp,  // Biased exponent, unbounded
  input  wire logic        [26:0]  mant, // 1.23 plus guard bits
  input  wire logic        [1:0]   mode, // Rounding mode
  output logic             [31:0]  word, // Rounded, flushed word
  output logic                     tiny  // Unrounded below 2^-126
);
  import fpsv_pkg::*;
  logic [9:0]  sh_w; // Denormalising shift, wide
  logic [4:0]  sh;   // Shift, capped
  logic [26:0] dn;   // Shifted significand
  logic        lost; // Bits shifted out
  logic        g;    // Guard bit
  logic        st;   // Sticky bit
  logic        inc;  // Round-up decision
  logic [24:0] sum;  // Rounded significand
  logic [9:0]  e;    // Working exponent
  // Tininess judged on the unrounded value
  assign tiny = (mant != '0) && (exp < 10'sh001);
  // Single rounding of the unrounded value
  always_comb
  begin
    sh_w = 10'h001 - exp;
    sh   = 5'h00;
    if (tiny)
      sh = (sh_w > 10'h01B) ? 5'h1B : sh_w[4:0];
    dn   = mant >> sh;
    lost = |(mant & ~(27'h7FF_FFFF << sh));
    g    = dn[2];
    st   = |dn[1:0] | lost;
    // Rounding direction per mode
    case (mode)
      RND_NEAR: inc = g & (st | dn[3]);
      RND_POS:  inc = ~sgn & (g | st);
      RND_NEG:  inc = sgn & (g | st);
      default: inc = 1'b0;
    endcase
    sum  = {1'b0, dn[26:3]} + {24'h00_0000, inc};
    e    = tiny ? 10'h001 : exp;
    word = {sgn, e[7:0], sum[22:0]};
    if (sum[24])
    begin
      // Carry out renormalises
      e    = e + 10'h001;
      word = {sgn, e[7:0], sum[23:1]};
    end
    if (mant == '0 || !(sum[24] | sum[23]))
      word = {sgn, 31'h0000_0000};
    else if ($signed(e) >= $signed({2'h0, EXP_ONES}))
      word = {sgn, EXP_ONES, 23'h00_0000};
  end
endmodule : fpsv_round

// ===== dv/fpsv_arith_model.sv
`timescale 1ns/1ps
// Arithmetic stand-in: answers each forward with a commanded result
module fpsv_arith_model (
  input  wire logic              clk,       // Core clock
  input  wire logic              ar_valid,  // Forward strobe
  input  wire logic              c_sign,    // Commanded sign
  input  wire logic signed [9:0] c_exp,     // Commanded exponent
  input  wire logic [26:0]       c_mant,    // Commanded mantissa
  input  wire logic              c_inv,     // Commanded invalid
  input  wire logic [7:0]        c_org,     // Commanded origin
  output logic                   res_valid, // Result strobe
  output logic                   res_sign,  // Result sign
  output logic signed [9:0]      res_exp,   // Result exponent
  output logic [26:0]            res_mant,  // Unrounded mantissa
  output logic                   res_inv,   // Invalid case
  output logic [7:0]             res_org    // Invalid origin
);
  // Known values from time zero
  initial {res_valid, res_sign, res_exp, res_mant, res_inv, res_org} = '0;
  // Answer one cycle after a forward, unrounded; fields not held after
  always @(posedge clk)
  begin
    res_valid <= ar_valid;
    {res_sign, res_exp, res_mant, res_inv, res_org} <= ar_valid ?
      {c_sign, c_exp, c_mant, c_inv, c_org} :
      ~{res_sign, res_exp, res_mant, res_inv, res_org};
  end
endmodule : fpsv_arith_model

// ===== dv/fp_special_value_handling_test.sv
`timescale 1ns/1ps
module fp_special_value_handling_test;
  import fpsv_pkg::*;
  logic              clk, rst, psel, penable, pwrite; // Clock, reset, APB
  logic [ADDR_W-1:0] paddr;                 // APB address
  logic [31:0]       pwdata, prdata, q;     // APB data, read result
  logic              pready, pslverr, e;    // APB answer, error seen
  logic              op_valid, ar_valid;    // Issue, forward strobes
  fpsv_op_t          op_code, ar_op, op;    // Op codes
  logic [31:0]       op_a, op_b, op_c, a, b, c; // Operands
  logic [31:0]       ar_a, ar_b, ar_c;      // Forwarded operands
  logic              res_valid, res_sign, res_inv; // Model answer
  logic signed [9:0] res_exp, c_exp;        // Unrounded exponent
  logic [26:0]       res_mant, c_mant;      // Unrounded mantissa
  logic [7:0]        res_org, c_org;        // Invalid origin
  logic              c_sign, c_inv;         // Commanded fields
  logic              fin_valid, imm_valid, cmp_denorm, exc_pulse;
  logic [31:0]       fin_word, imm_word;    // Result words
  logic [3:0]        cmp_flags;             // Compare outcome
  logic [1:0]        round_mode;            // Rounding mode
  logic              flag_inv, flag_unf;    // Sticky flags
  logic [31:0]       seed = 32'h92b5_bf12;  // Random state
  int                failures = 0;          // Mismatch count
  int                n_tests = 0;           // Comparison count

  // Device under test
  fpsv_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_c(op_c),
    .ar_valid(ar_valid), .ar_op(ar_op), .ar_a(ar_a), .ar_b(ar_b),
    .ar_c(ar_c), .res_valid(res_valid), .res_sign(res_sign),
    .res_exp(res_exp), .res_mant(res_mant), .res_inv(res_inv),
    .res_org(res_org), .fin_valid(fin_valid), .fin_word(fin_word),
    .imm_valid(imm_valid), .imm_word(imm_word), .cmp_flags(cmp_flags),
    .cmp_denorm(cmp_denorm), .exc_pulse(exc_pulse),
    .round_mode(round_mode), .flag_inv(flag_inv), .flag_unf(flag_unf));

  // Arithmetic side
  fpsv_arith_model arith (.clk(clk), .ar_valid(ar_valid),
    .c_sign(c_sign), .c_exp(c_exp), .c_mant(c_mant), .c_inv(c_inv),
    .c_org(c_org), .res_valid(res_valid), .res_sign(res_sign),
    .res_exp(res_exp), .res_mant(res_mant), .res_inv(res_inv),
    .res_org(res_org));

  // Pseudo-random step
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  // Operand without infinity or NaN, often denormal or zero
  function automatic logic [31:0] rnd();
    seed = lfsr(seed);
    rnd = seed;
    if (rnd[0]) rnd[30:23] = 8'h00;
    if (rnd[30:23] == 8'hFF) rnd[30] = 1'b0;
  endfunction : rnd

  // Denormal replaced by zero of its sign
  function automatic logic [31:0] flush(logic [31:0] x);
    return (x[30:23] == 8'h00) ? {x[31], 31'h0} : x;
  endfunction : flush

  // Compare and count
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask : chk

  // One op, outputs settled after its taking edge
  task automatic iss(fpsv_op_t o, logic [31:0] x, y, z);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= o;
    {op_a, op_b, op_c} <= {x, y, z};
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask : iss

  // APB transfer, waits for pready
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk("pready", 1, {31'h0, pready});
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // Result path: command model, issue, wait for final word
  task automatic res(logic s, logic signed [9:0] x, logic [26:0] m,
    logic i, logic [7:0] o);
    int n;
    n = 0;
    {c_sign, c_exp, c_mant, c_inv, c_org} = {s, x, m, i, o};
    iss(OP_MUL, 32'h3F80_0000, 32'h3F80_0000, 32'h0000_0000);
    while (fin_valid !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("fin_valid", 1, fin_valid);
  endtask : res

  // Verdict and end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  initial
  begin
    #2000000;
    failures++;
    summarize();
  end

  // Test sequence
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, op_valid} = '1;
    {psel, penable, pwrite, paddr, pwdata, op_valid} = '0;
    {op_code, op_a, op_b, op_c} = '0;
    {c_sign, c_exp, c_mant, c_inv, c_org} = {1'b0, 10'sd127, 27'h400_0000,
      9'h000};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(0, REG_STATUS, 0);
    chk("status", 0, q);
    $display("reset test done");
    // Random issue: classify and flush
    for (int i = 0; i < 24; i++)
    begin
      op = fpsv_op_t'({1'b0, seed[5:4]});
      a = rnd();
      b = rnd();
      c = rnd();
      iss(op, a, b, c);
      chk("ar_valid", 1, ar_valid);
      chk("ar_op", {29'h0, op}, {29'h0, ar_op});
      chk("ar_a", flush(a), ar_a);
      chk("ar_b", flush(b), ar_b);
      if (op[1]) chk("ar_c", flush(c), ar_c);
    end
    $display("flush test done");
    iss(OP_ADD, 32'h7FC0_0005, 32'h3F80_0000, 0);
    chk("imm_word", QNAN_FIXED, imm_word);
    chk("imm_valid", 1, {31'h0, imm_valid});
    chk("flag_inv", 0, flag_inv);
    iss(OP_MUL, 32'hFF80_0001, 32'h7FC0_0000, 0);
    chk("imm_word", QNAN_SNAN, imm_word);
    iss(OP_ADD, 32'h3F80_0000, 32'h3F80_0000, 0);
    chk("flag_inv", 1, flag_inv);
    apb(0, REG_STATUS, 0);
    chk("status_inv", 32'h4000_0000, q & 32'h4000_0000);
    iss(OP_UPDF, 32'h0200_0000, 0, 0);
    @(posedge clk);
    #1;
    chk("flags", 32'h0000_0008,
      {28'h0, round_mode, flag_inv, flag_unf});
    $display("nan test done");
    for (int m = 0; m < 4; m++)
    begin
      apb(1, REG_STATUS, m << 24);
      apb(0, REG_STATUS, 0);
      chk("status", m << 24, q);
    end
    apb(0, 12'h008, 0);
    chk("err", 32'h1, {31'h0, e});
    chk("unmapped", 0, q);
    $display("register test done");
    iss(OP_CMP, 32'h0000_0001, 32'h0000_0002, 0);
    chk("cmp", {27'h0, 1'b1, CMP_LT}, {27'h0, cmp_denorm, cmp_flags});
    apb(1, REG_LAST, 32'hFFFF_FFFF);
    apb(0, REG_LAST, 0);
    chk("last", {15'h0, CLS_DEN, CLS_DEN, 5'h0}, q & 32'h0001_FFE0);
    iss(OP_CMP, 32'h0000_0003, 32'h8000_0002, 0);
    chk("cmp", {27'h0, 1'b1, CMP_GT}, {27'h0, cmp_denorm, cmp_flags});
    iss(OP_CMP, 32'h8000_0000, 32'h0000_0000, 0);
    chk("cmp", {27'h0, 1'b0, CMP_EQ}, {27'h0, cmp_denorm, cmp_flags});
    iss(OP_CMP, 32'h7FC0_0000, 32'h0000_0000, 0);
    chk("cmp", {28'h0, CMP_UN}, {28'h0, cmp_flags});
    iss(OP_SEED, 32'h0000_0000, 0, 0);
    chk("seed", 32'h7F80_0000, imm_word);
    iss(OP_SEED, 32'hBF80_0000, 0, 0);
    chk("seed", QNAN_SEED, imm_word);
    iss(OP_UPDF, 0, 0, 0);
    $display("compare test done");
    res(1'b0, 10'sd127, 27'h400_0000, 1'b0, 8'h00);
    chk("fin", 32'h3F80_0000, fin_word);
    chk("exc", 0, {31'h0, exc_pulse});
    res(1'b1, 10'sd0, 27'h400_0000, 1'b0, 8'h00);
    chk("fin", 32'h8000_0000, fin_word);
    chk("exc", 1, {31'h0, exc_pulse});
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      res(seed[31], -10'(seed[3:0]), {2'b10, seed[24:0]}, 1'b0, 8'h00);
      chk("fin", {seed[31], 31'h0}, fin_word);
      chk("exc", 1, {31'h0, exc_pulse});
    end
    res(1'b0, 10'sd130, 27'h400_0000, 1'b0, 8'h00);
    chk("unf", 1, {31'h0, flag_unf});
    res(1'b0, 10'sd127, 27'h400_0000, 1'b1, seed[7:0]);
    chk("fin", QNAN_FIXED | seed[7:0], fin_word);
    chk("inv", 1, {31'h0, flag_inv});
    // Directed modes on 1.0 plus a sticky bit; minus sign in mode 2
    for (int m = 1; m < 4; m++)
    begin
      apb(1, REG_STATUS, m << 24);
      res(m == 2, 10'sd127, 27'h400_0001, 1'b0, 8'h00);
      chk("rnd", {m == 2, 8'h7F, 22'h0, m != 3}, fin_word);
    end
    $display("result test done");
    summarize();
  end
endmodule : fp_special_value_handling_test
